// ===== design/pattern_engine.v
// test-data generator and checker for the user data path
//
// Implementation choices: the placing of the registers and the strobed register port.
`include "pattern_engine_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module pattern_engine #(
  parameter CNT_W = 32
) (
  input  wire         clk_in,
  input  wire         srst_in,
  input  wire [3:0]   reg_addr_in,
  input  wire [31:0]  reg_wdata_in,
  input  wire         reg_wr_in,
  input  wire         reg_rd_in,
  output reg  [31:0]  reg_rdata_out,
  output wire         gen_push_strobe_out,
  output reg  [127:0] push_data_out,
  input  wire         push_fifo_nearly_full_in,
  output wire         pull_fifo_pop_out,
  input  wire [127:0] pull_data_in,
  input  wire         pull_fifo_vacant_in,
  output wire         gen_active_out,
  output wire         mismatch_flag_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one step of the 32-bit lfsr, taps at 31, 21, 1, 0
  function [31:0] lfsr_step;
    input [31:0] v;
    begin
      lfsr_step = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    end
  endfunction

  // build one 128-bit word from counters; header only in beat 0 of a block
  function [127:0] make_word;
    input [2:0]   patt;
    input [31:0]  cnt;
    input [63:0]  sect;
    input [127:0] lfsr4;
    input         first;
    reg   [127:0] body;
    begin
      body = 128'h0;
      case (patt)
        `PE_PATT_ZERO: body = {128{1'b0}};
        `PE_PATT_ONE:  body = {128{1'b1}};
        `PE_PATT_INC:  body = {4{cnt}};
        `PE_PATT_DEC:  body = {4{~cnt}};
        `PE_PATT_LFSR: body = lfsr4;
        default:       body = {128{1'b0}};
      endcase
      make_word = body;
      if (first && (patt == `PE_PATT_INC || patt == `PE_PATT_DEC ||
                    patt == `PE_PATT_LFSR)) begin
        make_word[63:0] = sect;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg              dir_rd_ff;
  reg              verify_ff;
  reg  [2:0]       patt_ff;
  reg  [63:0]      length_ff;
  reg  [63:0]      sect_init_ff;
  reg              launch_ff;
  reg              active_ff;
  reg              fail_ff;
  reg  [CNT_W-1:0] beat_counter_ff;
  reg  [63:0]      sector_index_counter_ff;
  reg  [31:0]      lfsr_ff;
  wire             launch_wr;
  wire             advance;
  wire [31:0]      l1;
  wire [31:0]      l2;
  wire [31:0]      l3;
  wire [31:0]      l4;
  wire [127:0]     nxt_word;
  wire [31:0]      cnt32;

  // a write with the start bit set and the dir bit clear makes a single-clock launch pulse
  assign launch_wr = reg_wr_in && (reg_addr_in == `PE_REG_CTRL) &&
                     reg_wdata_in[`PE_CTRL_START] && !reg_wdata_in[`PE_CTRL_DIR];

  always @(posedge clk_in) begin
    if (srst_in) begin
      dir_rd_ff    <= 1'b0;
      verify_ff    <= 1'b0;
      patt_ff      <= `PE_PATT_ZERO;
      length_ff    <= 64'h0;
      sect_init_ff <= 64'h0;
      launch_ff    <= 1'b0;
    end else begin
      launch_ff <= launch_wr;
      if (reg_wr_in) begin
        case (reg_addr_in)
          `PE_REG_CTRL: begin
            dir_rd_ff <= reg_wdata_in[`PE_CTRL_DIR];
            verify_ff <= reg_wdata_in[`PE_CTRL_VERIFY];
            patt_ff   <= reg_wdata_in[`PE_CTRL_PATT_MSB:`PE_CTRL_PATT_LSB];
          end
          `PE_REG_LEN_LO:  length_ff[31:0]     <= reg_wdata_in;
          `PE_REG_LEN_HI:  length_ff[63:32]    <= reg_wdata_in;
          `PE_REG_ADDR_LO: sect_init_ff[31:0]  <= reg_wdata_in;
          `PE_REG_ADDR_HI: sect_init_ff[63:32] <= reg_wdata_in;
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // flow control
  // ----------------------------------------------------------------
  wire [63:0] cnt_wide;
  wire        at_end;
  wire        new_run;

  assign cnt_wide = {{(64-CNT_W){1'b0}}, beat_counter_ff};
  assign at_end   = (cnt_wide == length_ff);
  // any start write, either direction, begins a fresh test
  assign new_run  = reg_wr_in && (reg_addr_in == `PE_REG_CTRL) &&
                    reg_wdata_in[`PE_CTRL_START];

  // combinational so that the strobe drops in the very cycle the count ends
  assign gen_push_strobe_out = active_ff && !at_end && !push_fifo_nearly_full_in;
  assign pull_fifo_pop_out   = !pull_fifo_vacant_in;
  assign advance  = gen_push_strobe_out || pull_fifo_pop_out;
  assign gen_active_out    = active_ff;
  assign mismatch_flag_out = fail_ff;
  assign cnt32 = beat_counter_ff[31:0];

  // look-ahead: four lfsr states per 128-bit beat
  assign l1 = lfsr_step(lfsr_ff);
  assign l2 = lfsr_step(l1);
  assign l3 = lfsr_step(l2);
  assign l4 = lfsr_step(l3);

  assign nxt_word = make_word(patt_ff, cnt32, sector_index_counter_ff,
                              {l4, l3, l2, l1},
                              cnt32[4:0] == 5'h00);

  always @(posedge clk_in) begin
    if (srst_in) begin
      active_ff               <= 1'b0;
      fail_ff                 <= 1'b0;
      beat_counter_ff         <= {CNT_W{1'b0}};
      sector_index_counter_ff <= 64'h0;
      lfsr_ff                 <= `PE_LFSR_SEED;
      push_data_out           <= 128'h0;
    end else if (new_run) begin
      active_ff               <= 1'b0;
      fail_ff                 <= 1'b0;
      beat_counter_ff         <= {CNT_W{1'b0}};
      sector_index_counter_ff <= sect_init_ff;
      lfsr_ff                 <= `PE_LFSR_SEED;
    end else begin
      if (launch_ff) begin
        active_ff <= 1'b1;
      end else if (active_ff && at_end) begin
        active_ff <= 1'b0;
      end
      if (advance) begin
        beat_counter_ff <= beat_counter_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        lfsr_ff         <= l4;
        push_data_out   <= nxt_word;
        if (cnt32[4:0] == `PE_BEATS_PER_BLK) begin
          sector_index_counter_ff <= sector_index_counter_ff + 64'h1;
        end
      end
      // set side of the flag; only reset or a new run clears it
      if (pull_fifo_pop_out && dir_rd_ff && verify_ff &&
          (pull_data_in != nxt_word)) begin
        fail_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 32'h0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `PE_REG_CTRL:    reg_rdata_out <= {25'h0, patt_ff, 1'b0, verify_ff, dir_rd_ff, 1'b0};
        `PE_REG_LEN_LO:  reg_rdata_out <= length_ff[31:0];
        `PE_REG_LEN_HI:  reg_rdata_out <= length_ff[63:32];
        `PE_REG_ADDR_LO: reg_rdata_out <= sect_init_ff[31:0];
        `PE_REG_ADDR_HI: reg_rdata_out <= sect_init_ff[63:32];
        `PE_REG_STATUS:  reg_rdata_out <= {30'h0, fail_ff, active_ff};
        `PE_REG_CNT_LO:  reg_rdata_out <= cnt_wide[31:0];
        `PE_REG_CNT_HI:  reg_rdata_out <= cnt_wide[63:32];
        `PE_REG_SECT_LO: reg_rdata_out <= sector_index_counter_ff[31:0];
        `PE_REG_SECT_HI: reg_rdata_out <= sector_index_counter_ff[63:32];
        default:         reg_rdata_out <= 32'h0;
      endcase
    end else begin
      reg_rdata_out <= 32'h0;
    end
  end

endmodule // pattern_engine

`default_nettype wire

// ===== design/pattern_engine_defines.vh
// constants of the test-pattern engine: register offsets, fields, pattern codes
`ifndef PATTERN_ENGINE_DEFINES_VH
`define PATTERN_ENGINE_DEFINES_VH
// ----------------------------------------------------------------
// register word offsets
// ----------------------------------------------------------------
`define PE_REG_CTRL      4'h0
`define PE_REG_LEN_LO    4'h1
`define PE_REG_LEN_HI    4'h2
`define PE_REG_ADDR_LO   4'h3
`define PE_REG_ADDR_HI   4'h4
`define PE_REG_STATUS    4'h5
`define PE_REG_CNT_LO    4'h6
`define PE_REG_CNT_HI    4'h7
`define PE_REG_SECT_LO   4'h8
`define PE_REG_SECT_HI   4'h9
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define PE_CTRL_START    0
`define PE_CTRL_DIR      1
`define PE_CTRL_VERIFY   2
`define PE_CTRL_PATT_LSB 4
`define PE_CTRL_PATT_MSB 6
// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define PE_STAT_ACTIVE   0
`define PE_STAT_FAIL     1
// ----------------------------------------------------------------
// pattern codes
// ----------------------------------------------------------------
`define PE_PATT_ZERO     3'h0
`define PE_PATT_ONE      3'h1
`define PE_PATT_INC      3'h2
`define PE_PATT_DEC      3'h3
`define PE_PATT_LFSR     3'h4
// ----------------------------------------------------------------
// block layout: 512 bytes is 32 words of 128 bits
// ----------------------------------------------------------------
`define PE_BEATS_PER_BLK 5'h1F
`define PE_LFSR_SEED     32'h00000001
`endif

// ===== verif/pattern_engine_asserts.sv
// port assertions of the pattern engine
`timescale 1ns/100ps
`default_nettype none
module pattern_engine_asserts (
  input wire logic        clk_in,
  input wire logic        srst_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        gen_push_strobe_out,
  input wire logic        push_fifo_nearly_full_in,
  input wire logic        pull_fifo_pop_out,
  input wire logic        pull_fifo_vacant_in,
  input wire logic        gen_active_out,
  input wire logic        mismatch_flag_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence s_start;
    reg_wr_in && reg_addr_in == 4'h0 && reg_wdata_in[0];
  endsequence
  sequence s_wr_start;
    reg_wr_in && reg_addr_in == 4'h0 && reg_wdata_in[0] && !reg_wdata_in[1];
  endsequence
  a_launch_delay: assert property (s_wr_start |=> !gen_active_out ##1 gen_active_out)
    else $error("write run not active two cycles after start");
  a_push_gate: assert property (gen_push_strobe_out |-> gen_active_out && !push_fifo_nearly_full_in)
    else $error("push outside an active unstalled run");
  a_end_drop: assert property (gen_active_out && !gen_push_strobe_out && !push_fifo_nearly_full_in
    |=> !gen_active_out)
    else $error("run kept going after reaching its length");
  a_run_continues: assert property (gen_push_strobe_out && !reg_wr_in |=> gen_active_out)
    else $error("run ended in the cycle after a push");
  a_pop_follows: assert property (pull_fifo_pop_out == !pull_fifo_vacant_in)
    else $error("pop does not follow inbound fill state");
  a_fail_cause: assert property ($rose(mismatch_flag_out) |-> $past(pull_fifo_pop_out))
    else $error("mismatch raised without a popped word");
  a_fail_sticky: assert property (mismatch_flag_out && !(reg_wr_in && reg_addr_in == 4'h0
    && reg_wdata_in[0]) |=> mismatch_flag_out)
    else $error("mismatch cleared without a new run");
  a_fail_clear: assert property (s_wr_start |=> !mismatch_flag_out)
    else $error("mismatch not cleared by a new run");
  a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("read data outside the read answer cycle");
  c_start: cover property (s_start);
endmodule // pattern_engine_asserts
bind pattern_engine pattern_engine_asserts i_pattern_engine_asserts (.clk_in, .srst_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .gen_push_strobe_out,
  .push_fifo_nearly_full_in, .pull_fifo_pop_out, .pull_fifo_vacant_in, .gen_active_out,
  .mismatch_flag_out);
`default_nettype wire

// ===== verif/fifo_partner.sv
// model of the outbound and inbound fifos, looping written words back
`timescale 1ns/100ps
`default_nettype none
module fifo_partner (
  input wire logic          clk_in,
  input wire logic          push_in,
  input wire logic [127:0]  push_data_in,
  input wire logic          pop_in,
  input wire logic          stall_in,
  input wire logic          feed_in,
  input wire logic          flip_in,
  output var logic          nearly_full_out,
  output var logic          vacant_out,
  output var logic [127:0]  pull_data_out
);
  logic [127:0] q[$];
  logic         was_push;
  initial begin
    nearly_full_out = 1'b0;
    vacant_out = 1'b1;
    was_push = 1'b0;
    pull_data_out = 128'h0;
  end
  // data lags the strobe one cycle, so capture on the cycle after it
  always @(posedge clk_in) begin
    if (was_push) q.push_back(push_data_in);
    if (pop_in && !vacant_out) void'(q.pop_front());
    was_push <= push_in;
    nearly_full_out <= stall_in && ($urandom % 4 == 0);
    vacant_out <= !feed_in || q.size() == 0;
    // a vacant fifo shows junk, never the last word
    pull_data_out <= (!feed_in || q.size() == 0) ? {4{$urandom}} : q[0] ^ {127'h0, flip_in};
  end
endmodule // fifo_partner
`default_nettype wire

// ===== verif/test_pattern_engine.sv
// self-checking bench for the pattern engine
`timescale 1ns/100ps
`default_nettype none
module test_pattern_engine;
  logic         clk_in, srst_in, reg_wr_in, reg_rd_in;
  logic [3:0]   reg_addr_in;
  logic [31:0]  reg_wdata_in, reg_rdata_out;
  logic         push, full, pop, vacant, act, fail, stall, feed, flip, was_push;
  logic [127:0] pdata, qdata;
  logic [127:0] exp_q[$];
  logic [63:0]  sect;
  logic [2:0]   patt;
  logic [31:0]  lf, la, lb, lc;
  int           bad_count, n_checks, len, i;
  pattern_engine i_pattern_engine (.clk_in, .srst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .gen_push_strobe_out(push), .push_data_out(pdata),
    .push_fifo_nearly_full_in(full), .pull_fifo_pop_out(pop), .pull_data_in(qdata),
    .pull_fifo_vacant_in(vacant), .gen_active_out(act), .mismatch_flag_out(fail));
  fifo_partner i_fifo_partner (.clk_in, .push_in(push), .push_data_in(pdata), .pop_in(pop),
    .stall_in(stall), .feed_in(feed), .flip_in(flip), .nearly_full_out(full),
    .vacant_out(vacant), .pull_data_out(qdata));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    // one idle edge so a following call never re-raises the strobe in this step
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    cmp({96'h0, reg_rdata_out}, {96'h0, e});
    @(posedge clk_in);
  endtask
  task automatic settle;
    int n;
    repeat (3) @(posedge clk_in);
    for (n = 0; n < 1000 && (act || !vacant); n++) @(posedge clk_in);
    if (n == 1000) begin
      bad_count++;
      give_verdict();
    end
  endtask
  // one lfsr step of x31 + x21 + x + 1, written from the polynomial
  function automatic logic [31:0] lstep(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [127:0] expw(input logic [2:0] p, input int c, input logic [63:0] s,
                                        input logic [127:0] lw);
    logic [127:0] w;
    w = p == 3'h1 ? {128{1'b1}} : p == 3'h2 ? {4{c[31:0]}} : p == 3'h3 ? ~{4{c[31:0]}} :
        p == 3'h4 ? lw : 128'h0;
    if (p > 3'h1 && c % 32 == 0) w[63:0] = s + c / 32;
    return w;
  endfunction
  // watcher: the word of a push shows one cycle after its strobe
  always @(posedge clk_in) begin
    if (was_push) begin
      if (exp_q.size() > 0) cmp(pdata, exp_q.pop_front());
      else begin
        bad_count++;
        $display("Error at %0t: push beyond the programmed length", $time);
      end
    end
    was_push <= push;
  end
  initial begin
    {srst_in, reg_wr_in, reg_rd_in, stall, feed, flip} = 6'h20;
    {reg_addr_in, reg_wdata_in, bad_count, n_checks} = 0;
    void'($urandom(32'h709941D5));
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(4'hF, 32'h0);
    for (i = 0; i < 5; i++) begin
      patt = i[2:0];
      len = 33 + $urandom % 8;
      sect = {$urandom, $urandom};
      wr(4'h1, len);
      wr(4'h2, 32'h0);
      wr(4'h3, sect[31:0]);
      wr(4'h4, sect[63:32]);
      lf = 32'h00000001;
      for (int c = 0; c < len; c++) begin
        la = lstep(lf);
        lb = lstep(la);
        lc = lstep(lb);
        lf = lstep(lc);
        exp_q.push_back(expw(patt, c, sect, {lf, lc, lb, la}));
      end
      stall <= 1'b1;
      wr(4'h0, {25'h0, patt, 4'h1});
      settle();
      stall <= 1'b0;
      rd(4'h6, len);
      rd(4'h5, 32'h0);
      // read back the looped words; lfsr is judged by the checker agreeing with the generator
      wr(4'h0, {25'h0, patt, 1'b0, patt != 3'h2, 2'h3});
      feed <= 1'b1;
      repeat (4) @(posedge clk_in);
      flip <= patt inside {3'h2, 3'h3};
      @(posedge clk_in);
      flip <= 1'b0;
      settle();
      feed <= 1'b0;
      rd(4'h5, {30'h0, patt == 3'h3, 1'b0});
      rd(4'h6, len);
      rd(4'h8, sect[31:0] + 32'h1);
    end
    cmp(128'(exp_q.size()), 128'h0);
    give_verdict();
  end
endmodule // test_pattern_engine
`default_nettype wire
